// *** design/arith_unit.sv ***
// Accumulator unit for binary subtract, multiply and divide.
// Assumes an AXI4-Lite master and a memory that answers mem_req
// with mem_ack and mem_rdata in the same cycle.
`timescale 1ns/100ps
`include "arith_consts.svh"

module arith_unit
  import arith_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             mem_req,
  output logic [15:0]      mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic             irq
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  state_t      state_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [3:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_fire;
  logic        wr_ok;
  logic [1:0]  op_r;
  logic [1:0]  src_r;
  logic [31:0] imm_r;
  logic [15:0] base_r;
  logic [15:0] addr_r;
  logic [31:0] opnd_r;
  logic [31:0] acc_r;
  logic [31:0] stack_r;
  logic [31:0] quo_r;
  logic [15:0] rem_r;
  logic [4:0]  cnt_r;
  logic [4:0]  flags_r;
  logic [1:0]  ist_r;
  logic [1:0]  ien_r;
  logic        start;
  logic        busy;
  logic        div_zero;
  logic        div_last;
  logic        exec_done;
  logic        done_evt;
  logic [31:0] sub_res;
  logic [31:0] mul_res;
  logic [16:0] div_sh;
  logic        div_ge;
  logic [15:0] rem_nxt;
  logic [31:0] quo_nxt;
  logic [31:0] rd_val;
  logic        rd_ok;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_fire       = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_ok         = awaddr_r <= `REG_MEM_ADDR;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      awaddr_r     <= 4'h0;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr[5:2])
      `REG_CTRL:     rd_val = {28'h0, src_r, op_r};
      `REG_IMM_LO:   rd_val = {16'h0, imm_r[15:0]};
      `REG_IMM_HI:   rd_val = {16'h0, imm_r[31:16]};
      `REG_ACC:      rd_val = acc_r;
      `REG_STACK1:   rd_val = stack_r;
      `REG_FLAGS:    rd_val = {23'h0, busy, 3'h0, flags_r};
      `REG_IRQ_STAT: rd_val = {30'h0, ist_r};
      `REG_IRQ_CLR:  rd_val = 32'h0000_0000;
      `REG_IRQ_EN:   rd_val = {30'h0, ien_r};
      `REG_MEM_ADDR: rd_val = {16'h0, base_r};
      default:       rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Command and operand set-up registers
  // ****************************************
  assign busy  = state_r != ST_IDLE;
  // A start while busy is dropped; the running operation owns acc
  assign start = wr_fire && awaddr_r == `REG_CTRL && wstrb_r[0] && !busy;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_r   <= `OP_SUBW;
      src_r  <= `SRC_MEM;
      imm_r  <= 32'h0000_0000;
      base_r <= 16'h0000;
    end else if (wr_fire) begin
      case (awaddr_r)
        `REG_CTRL: begin
          if (start) begin
            op_r  <= wdata_r[1:0];
            src_r <= wdata_r[3:2];
          end
        end
        // Immediate halves are 16 bits; word ops use the low half only
        `REG_IMM_LO: begin
          imm_r[15:0] <= 16'(merge({16'h0, imm_r[15:0]}, wdata_r,
                                   wstrb_r));
        end
        `REG_IMM_HI: begin
          imm_r[31:16] <= 16'(merge({16'h0, imm_r[31:16]}, wdata_r,
                                    wstrb_r));
        end
        `REG_MEM_ADDR: begin
          base_r <= 16'(merge({16'h0, base_r}, wdata_r, wstrb_r));
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Arithmetic
  // ****************************************
  // word and double difference
  assign sub_res  = acc_r - opnd_r;
  assign mul_res  = acc_r[15:0] * opnd_r[15:0];
  assign div_zero = opnd_r[15:0] == 16'h0000;
  assign div_sh   = {rem_r, quo_r[31]};
  assign div_ge   = div_sh >= {1'b0, opnd_r[15:0]};
  assign rem_nxt  = div_ge ? 16'(div_sh - {1'b0, opnd_r[15:0]})
                           : div_sh[15:0];
  assign quo_nxt  = {quo_r[30:0], div_ge};
  assign div_last = state_r == ST_DIV && cnt_r == `DIV_STEPS;
  assign exec_done = state_r == ST_EXEC && !(op_r == `OP_DIV && !div_zero);
  assign done_evt = exec_done || div_last;

  // ****************************************
  // Sequencer and datapath
  // ****************************************
  assign mem_req  = state_r == ST_PTR || state_r == ST_FETCH_LO ||
                    state_r == ST_FETCH_HI;
  assign mem_addr = addr_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      addr_r  <= 16'h0000;
      opnd_r  <= 32'h0000_0000;
      acc_r   <= `ACC_RST;
      stack_r <= `ACC_RST;
      quo_r   <= 32'h0000_0000;
      rem_r   <= 16'h0000;
      cnt_r   <= 5'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (wr_fire && awaddr_r == `REG_ACC) begin
            acc_r <= merge(acc_r, wdata_r, wstrb_r);
          end
          if (wr_fire && awaddr_r == `REG_STACK1) begin
            stack_r <= merge(stack_r, wdata_r, wstrb_r);
          end
          if (start) begin
            addr_r <= base_r;
            if (wdata_r[3:2] == `SRC_MEM) begin
              state_r <= ST_FETCH_LO;
            end else if (wdata_r[3:2] == `SRC_PTR) begin
              state_r <= ST_PTR;
            end else begin
              opnd_r  <= (wdata_r[1:0] == `OP_SUBD) ? imm_r
                         : {16'h0, imm_r[15:0]};
              state_r <= ST_EXEC;
            end
          end
        end
        ST_PTR: begin
          if (mem_ack) begin
            addr_r  <= mem_rdata;
            state_r <= ST_FETCH_LO;
          end
        end
        ST_FETCH_LO: begin
          if (mem_ack) begin
            opnd_r <= {16'h0, mem_rdata};
            if (op_r == `OP_SUBD) begin
              addr_r  <= addr_r + 16'h0001;
              state_r <= ST_FETCH_HI;
            end else begin
              state_r <= ST_EXEC;
            end
          end
        end
        ST_FETCH_HI: begin
          if (mem_ack) begin
            opnd_r[31:16] <= mem_rdata;
            state_r       <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_r <= ST_IDLE;
          case (op_r)
            `OP_SUBW, `OP_SUBD: acc_r <= sub_res;
            `OP_MUL:            acc_r <= mul_res;
            default: begin
              // zero divisor leaves acc and stack
              if (!div_zero) begin
                quo_r   <= acc_r;
                rem_r   <= 16'h0000;
                cnt_r   <= 5'h00;
                state_r <= ST_DIV;
              end
            end
          endcase
        end
        ST_DIV: begin
          // Restoring divide, one quotient bit per cycle to save area
          quo_r <= quo_nxt;
          rem_r <= rem_nxt;
          cnt_r <= cnt_r + 5'h01;
          if (div_last) begin
            acc_r   <= quo_nxt;
            stack_r <= {16'h0, rem_nxt};
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  // only the flags an operation drives change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_r <= `FLAGS_RST;
    end else if (exec_done) begin
      if (op_r == `OP_DIV) begin
        flags_r[`FLG_OVF] <= 1'b1;
      end else begin
        flags_r[`FLG_ZERO] <= (op_r == `OP_MUL) ? mul_res == 32'h0
                                                : sub_res == 32'h0;
        flags_r[`FLG_NEG]  <= (op_r == `OP_MUL) ? mul_res[31]
                                                : sub_res[31];
        if (op_r != `OP_MUL) begin
          // borrow out of bit 15 and bit 31
          flags_r[`FLG_B16] <= acc_r[15:0] < opnd_r[15:0];
          flags_r[`FLG_B32] <= acc_r < opnd_r;
        end
      end
    end else if (div_last) begin
      flags_r[`FLG_ZERO] <= quo_nxt == 32'h0;
      flags_r[`FLG_NEG]  <= quo_nxt[31];
      flags_r[`FLG_OVF]  <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt status, clear and enable
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ist_r <= 2'h0;
      ien_r <= 2'h0;
    end else begin
      if (wr_fire && awaddr_r == `REG_IRQ_EN && wstrb_r[0]) begin
        ien_r <= wdata_r[1:0];
      end
      // Set beats clear so an event in the clear cycle survives
      for (int i = 0; i < 2; i++) begin
        if (wr_fire && awaddr_r == `REG_IRQ_CLR && wstrb_r[0] &&
            wdata_r[i]) begin
          ist_r[i] <= 1'b0;
        end
      end
      if (done_evt) begin
        ist_r[`IRQ_DONE] <= 1'b1;
      end
      if (exec_done && op_r == `OP_DIV) begin
        ist_r[`IRQ_OVF] <= 1'b1;
      end
    end
  end

  assign irq = |(ist_r & ien_r);

  // ****************************************
  // Checks
  // ****************************************
  sequence exec_op(logic [1:0] o);
    state_r == ST_EXEC && op_r == o;
  endsequence

  sequence div_run;
    state_r == ST_EXEC && op_r == `OP_DIV && !div_zero ##1
      state_r == ST_DIV [*8];
  endsequence

  sub_word_result_a: assert property (
    exec_op(`OP_SUBW) |=> acc_r == $past(acc_r) - $past(opnd_r))
    else $error("word subtract result wrong");

  sub_dbl_result_a: assert property (
    exec_op(`OP_SUBD) |=> acc_r == $past(acc_r) - $past(opnd_r))
    else $error("double subtract result wrong");

  mul_product_a: assert property (
    exec_op(`OP_MUL) |=>
      acc_r == $past(acc_r[15:0]) * $past(opnd_r[15:0]))
    else $error("multiply product wrong");

  zero_flag_a: assert property (
    done_evt && !(state_r == ST_EXEC && op_r == `OP_DIV) |=>
      flags_r[`FLG_ZERO] == (acc_r == 32'h0))
    else $error("zero flag disagrees with acc");

  neg_flag_a: assert property (
    done_evt && !(state_r == ST_EXEC && op_r == `OP_DIV) |=>
      flags_r[`FLG_NEG] == acc_r[31])
    else $error("negative flag disagrees with acc");

  borrow_flags_a: assert property (
    exec_op(`OP_SUBW) |=>
      flags_r[`FLG_B16] == ($past(acc_r[15:0]) < $past(opnd_r[15:0])) &&
      flags_r[`FLG_B32] == ($past(acc_r) < $past(opnd_r)))
    else $error("borrow flags wrong");

  div_finish_a: assert property (
    div_run |-> ##25 !busy &&
      acc_r * $past(opnd_r[15:0], 25) + stack_r == $past(acc_r, 33) &&
      !flags_r[`FLG_OVF])
    else $error("divide result or timing wrong");

  div_zero_hold_a: assert property (
    state_r == ST_EXEC && op_r == `OP_DIV && div_zero |=> $stable(acc_r) &&
      $stable(stack_r) && flags_r[`FLG_OVF] && !busy)
    else $error("divide by zero handling wrong");

  flags_idle_a: assert property (
    !done_evt |=> $stable(flags_r))
    else $error("flags moved without an operation");

endmodule

// *** design/arith_consts.svh ***
// Constants for the binary subtract, multiply and divide unit.
// Assumes an AXI4-Lite master and a word-wide operand memory port.
// Summary of operation
// - Word subtract: accumulator minus 16-bit operand, back into accumulator.
// - Word subtract/multiply operand: one memory word or 0-FFFF immediate.
// - Double subtract: 32-bit accumulator minus 32-bit operand, kept there.
// - Double operand: two consecutive memory words or eight-digit immediate.
// - Zero flag set when accumulator result is zero, else cleared.
// - Borrow16 flag set on borrow out of bit 15.
// - Borrow32 flag set on borrow out of bit 31.
// - Negative flag shows a negative result for every operation but a divide by zero, which leaves it.
// - Word multiply: low accumulator times operand, 32-bit product kept.
// - Word divide: accumulator over 16-bit operand, quotient to accumulator.
// - Word divide writes the remainder into stack level one.
// - Divide operand: one memory word or immediate within 0-FFFF.
// - Divide sets operand overflow when the operand cannot be used.
// - Flags hold until an operation that drives them rewrites them.
// - Operand may also come through a pointer word in memory.
`ifndef ARITH_CONSTS_SVH
`define ARITH_CONSTS_SVH

// ****************************************
// Register word indices (address bits 5:2)
// ****************************************
`define REG_CTRL      4'h0
`define REG_IMM_LO    4'h1
`define REG_IMM_HI    4'h2
`define REG_ACC       4'h3
`define REG_STACK1    4'h4
`define REG_FLAGS     4'h5
`define REG_IRQ_STAT  4'h6
`define REG_IRQ_CLR   4'h7
`define REG_IRQ_EN    4'h8
`define REG_MEM_ADDR  4'h9

// ****************************************
// Field codes and positions
// ****************************************
`define OP_SUBW       2'h0
`define OP_SUBD       2'h1
`define OP_MUL        2'h2
`define OP_DIV        2'h3
`define SRC_MEM       2'h0
`define SRC_PTR       2'h1
`define SRC_IMM       2'h2
`define FLG_ZERO      0
`define FLG_NEG       1
`define FLG_B16       2
`define FLG_B32       3
`define FLG_OVF       4
`define FLG_BUSY      8
`define IRQ_DONE      0
`define IRQ_OVF       1

// ****************************************
// Reset values and counts
// ****************************************
`define ACC_RST       32'h0000_0000
`define FLAGS_RST     5'h00
`define DIV_STEPS     5'h1f
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// *** design/arith_pkg.sv ***
// Types shared by the arithmetic unit.
// Assumes arith_consts.svh supplies the numeric constants.
package arith_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PTR,
    ST_FETCH_LO,
    ST_FETCH_HI,
    ST_EXEC,
    ST_DIV
  } state_t;
endpackage

// *** bench/op_memory.sv ***
// Operand memory model that answers the unit's fetch port.
// Assumes the bench fills words directly; one fetch outstanding.
`timescale 1ns/100ps

module op_memory
  import arith_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [15:0] words [0:255];
  logic [1:0]  wait_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_r    <= 2'h0;
    end else if (mem_req && !mem_ack && wait_r == 2'h0) begin
      mem_ack   <= 1'b1;
      mem_rdata <= words[mem_addr[7:0]];
      wait_r    <= 2'($urandom_range(3));
    end else begin
      // Data off the bus toggles so a late sample cannot match
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && wait_r != 2'h0) wait_r <= wait_r - 2'h1;
    end
  end
endmodule

// *** bench/test_arith_unit.sv ***
// Bench for arith_unit: AXI4-Lite master, read queue and monitor.
// Assumes op_memory on the fetch port and irq as completion.
`timescale 1ns/100ps
`include "arith_consts.svh"

module test_arith_unit
  import arith_pkg::*;
;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, mem_req, mem_ack, irq;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, acc_m, stk_m, o;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, op, src;
  logic [15:0] mem_addr, mem_rdata;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  logic [33:0] e;
  logic [4:0]  flg_m;
  logic        en_m, ovf_m;
  int          error_cnt, comparisons, cyc;

  arith_unit dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .irq(irq));
  op_memory mem_u (.clk(clk), .rst(rst), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #50 clk = ~clk;

  // ********************************
  // Checking and verdict
  // ********************************
  task automatic check(input logic [31:0] seen, exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s mismatch", $time, msg);
    end
  endtask

  task automatic conclude;
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Monitor samples pre-edge values; all watched outputs are registers
  always @(posedge clk) begin
    if (bvalid && bready) begin
      check(32'(bresp), 32'(exp_b.pop_front()), "bresp");
    end
    if (rvalid && rready) begin
      e = exp_r.pop_front();
      check(32'(rresp), 32'(e[33:32]), "rresp");
      if (e[33:32] == `RESP_OKAY) check(rdata, e[31:0], "rdata");
    end
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      conclude();
    end
  end

  // ********************************
  // Bus cycles
  // ********************************
  // Handshakes judged at the falling edge, released after the rising one
  task automatic axi_wr(input logic [3:0] idx, input logic [31:0] d,
                        input logic [1:0] er);
    logic ah, wh, bh;
    exp_b.push_back(er);
    @(posedge clk);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (!bh);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] idx, input logic [31:0] d,
                        input logic [1:0] er);
    logic ah, rh;
    exp_r.push_back({er, d});
    @(posedge clk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      ah = arvalid && arready;
      rh = rvalid && rready;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
    end while (!rh);
    rready <= 1'b0;
  endtask

  task automatic chk_all;
    axi_rd(`REG_ACC, acc_m, `RESP_OKAY);
    axi_rd(`REG_STACK1, stk_m, `RESP_OKAY);
    axi_rd(`REG_FLAGS, 32'(flg_m), `RESP_OKAY);
  endtask

  task automatic set_acc(input logic [31:0] v);
    axi_wr(`REG_ACC, v, `RESP_OKAY);
    acc_m = v;
  endtask

  // ********************************
  // One operation with expected state
  // ********************************
  task automatic do_op(input logic [1:0] op, src, input logic [31:0] o);
    logic [31:0] w;
    int          n;
    w = (op == `OP_SUBD) ? o : {16'h0, o[15:0]};
    axi_wr(`REG_IMM_LO, {16'h0, o[15:0]}, `RESP_OKAY);
    axi_wr(`REG_IMM_HI, {16'h0, o[31:16]}, `RESP_OKAY);
    mem_u.words[8'h10] = o[15:0];
    mem_u.words[8'h11] = o[31:16];
    mem_u.words[8'h20] = o[15:0];
    mem_u.words[8'h21] = o[31:16];
    mem_u.words[8'h40] = 16'h0020;
    axi_wr(`REG_MEM_ADDR, (src == `SRC_PTR) ? 32'h40 : 32'h10, `RESP_OKAY);
    if (op == `OP_DIV && w == 32'h0) begin
      flg_m[`FLG_OVF] = 1'b1;
      ovf_m = 1'b1;
    end else begin
      if (op == `OP_DIV) begin
        stk_m = acc_m % w;
        acc_m = acc_m / w;
        flg_m[`FLG_OVF] = 1'b0;
      end else if (op == `OP_MUL) acc_m = acc_m[15:0] * w[15:0];
      else begin
        flg_m[`FLG_B16] = acc_m[15:0] < w[15:0];
        flg_m[`FLG_B32] = acc_m < w;
        acc_m = acc_m - w;
      end
      flg_m[`FLG_ZERO] = acc_m == 32'h0;
      flg_m[`FLG_NEG] = acc_m[31];
    end
    axi_wr(`REG_CTRL, {28'h0, src, op}, `RESP_OKAY);
    if (en_m) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (irq !== 1'b1 && n < 300);
      // A missing completion counts here instead of passing silently
      check(32'(irq), 32'h1, "irq on completion");
      axi_wr(`REG_IRQ_CLR, 32'h1, `RESP_OKAY);
      @(negedge clk);
      check(32'(irq), 32'(ovf_m), "irq after clear");
    end else begin
      // No completion signal while masked; longest op is under 60
      repeat (60) @(negedge clk);
      check(32'(irq), 32'h0, "masked irq");
    end
  endtask

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 6'h00;
    araddr = 6'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    {acc_m, stk_m, flg_m, en_m, ovf_m} = '0;
    {error_cnt, comparisons, cyc} = '0;
    void'($urandom(32'h91802d6c));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk_all();
    axi_rd(`REG_IRQ_EN, 32'h0, `RESP_OKAY);
    axi_rd(4'hb, 32'h0, `RESP_SLVERR);
    axi_wr(4'hb, 32'h5, `RESP_SLVERR);
    axi_wr(`REG_IRQ_EN, 32'h3, `RESP_OKAY);
    en_m = 1'b1;
    set_acc(32'h5);
    do_op(`OP_SUBW, `SRC_IMM, 32'h0001_0007);
    chk_all();
    set_acc(32'h1234);
    do_op(`OP_SUBW, `SRC_MEM, 32'hffff_1234);
    chk_all();
    set_acc(32'h1);
    do_op(`OP_SUBD, `SRC_PTR, 32'h2);
    chk_all();
    set_acc(32'hffff);
    do_op(`OP_MUL, `SRC_MEM, 32'hffff);
    chk_all();
    set_acc(32'h0012_3457);
    do_op(`OP_DIV, `SRC_IMM, 32'h10);
    chk_all();
    do_op(`OP_DIV, `SRC_MEM, 32'h0);
    chk_all();
    axi_wr(`REG_IRQ_CLR, 32'h2, `RESP_OKAY);
    ovf_m = 1'b0;
    @(negedge clk);
    check(32'(irq), 32'h0, "irq cleared");
    axi_wr(`REG_IRQ_EN, 32'h0, `RESP_OKAY);
    en_m = 1'b0;
    do_op(`OP_SUBD, `SRC_IMM, 32'h8000_0001);
    axi_rd(`REG_IRQ_STAT, 32'h1, `RESP_OKAY);
    axi_wr(`REG_IRQ_EN, 32'h3, `RESP_OKAY);
    en_m = 1'b1;
    @(negedge clk);
    check(32'(irq), 32'h1, "enabled irq");
    axi_wr(`REG_IRQ_CLR, 32'h1, `RESP_OKAY);
    for (int i = 0; i < 24; i++) begin
      set_acc($urandom);
      op = 2'(i % 4);
      src = 2'((i / 4) % 3);
      o = $urandom;
      if (op == `OP_DIV && o[15:0] == 16'h0) o = 32'h1;
      do_op(op, src, o);
      chk_all();
    end
    conclude();
  end
endmodule
